/* File: src/tta_pkg.sv */
// Package with field layouts, sizes and codes for the buffer test access.
package tta_pkg;
  localparam int TTA_ENTRIES = 32;
  localparam int TTA_WAYS = 4;
  localparam int TTA_SETS = TTA_ENTRIES / TTA_WAYS;
  localparam int TTA_IDX_W = 3;
  localparam int TTA_PAGE_W = 20;
  localparam int TTA_PAGE_LSB = 12;
  localparam int TTA_PAGE_MSB = 31;
  localparam int TTA_CMD_BIT = 0;
  localparam int TTA_VALID_BIT = 11;
  localparam int TTA_DIRTY_LSB = 9;
  localparam int TTA_USER_LSB = 7;
  localparam int TTA_RW_LSB = 5;
  localparam int TTA_LRU_LSB = 7;
  localparam int TTA_HIT_BIT = 4;
  localparam int TTA_SET_LSB = 2;
  localparam logic [31:0] TTA_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TTA_DATA_RST = 32'h0000_0000;
  localparam logic [31:0] TTA_CTRL_MASK = 32'hffff_ffe1;
  localparam logic [31:0] TTA_DATA_MASK = 32'hffff_f39c;
  localparam logic [1:0] TTA_PAIR_CLR = 2'h1;
  localparam logic [1:0] TTA_PAIR_SET = 2'h2;
  typedef enum logic [1:0] {
    TTA_IDLE = 2'b00,
    TTA_RUN = 2'b01
  } tta_state_t;
  // Stored tag: valid, dirty, user, read-write, linear page.
  typedef struct packed {
    logic valid;
    logic dirty;
    logic user;
    logic rw;
    logic [TTA_PAGE_W-1:0] page;
  } tta_tag_t;
endpackage : tta_pkg

/* File: src/tta_entry_if.sv */
// Interface between the access sequencer and the translation buffer array.
`timescale 1ns/10ps
`default_nettype none
interface tta_entry_if;
  logic [tta_pkg::TTA_IDX_W-1:0] idx;
  logic wr;
  logic [1:0] wr_way;
  tta_pkg::tta_tag_t wr_tag;
  logic [tta_pkg::TTA_PAGE_W-1:0] wr_phys;
  tta_pkg::tta_tag_t rd_tag [tta_pkg::TTA_WAYS];
  logic [tta_pkg::TTA_PAGE_W-1:0] rd_phys [tta_pkg::TTA_WAYS];
  logic [2:0] rd_lru;
  logic touch;
  logic [1:0] touch_way;
  modport ctl (output idx, wr, wr_way, wr_tag, wr_phys, touch, touch_way,
    input rd_tag, rd_phys, rd_lru);
  modport mem (input idx, wr, wr_way, wr_tag, wr_phys, touch, touch_way,
    output rd_tag, rd_phys, rd_lru);
endinterface : tta_entry_if
`default_nettype wire

/* File: src/tta_array.sv */
// Four-way translation buffer storage with per-set pseudo-LRU bits.
`timescale 1ns/10ps
`default_nettype none
module tta_array (
  input wire logic clk_i,
  input wire logic srst_i,
  tta_entry_if.mem ent
);
  import tta_pkg::*;
  tta_tag_t tag_ff [TTA_SETS][TTA_WAYS];
  logic [TTA_PAGE_W-1:0] phys_ff [TTA_SETS][TTA_WAYS];
  logic [2:0] lru_ff [TTA_SETS];

  // Bit 0 picks the pair, bit 1 the way in pair 0/1, bit 2 in pair 2/3.
  function automatic logic [2:0] lru_upd(input logic [2:0] l,
                                         input logic [1:0] w);
    logic [2:0] r;
    r = l;
    r[0] = ~w[1];
    if (!w[1]) begin
      r[1] = ~w[0];
    end else begin
      r[2] = ~w[0];
    end
    return r;
  endfunction : lru_upd

  always_comb begin
    for (int w = 0; w < TTA_WAYS; w++) begin
      ent.rd_tag[w] = tag_ff[ent.idx][w];
      ent.rd_phys[w] = phys_ff[ent.idx][w];
    end
  end
  assign ent.rd_lru = lru_ff[ent.idx];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int s = 0; s < TTA_SETS; s++) begin
        lru_ff[s] <= 3'h0;
        for (int w = 0; w < TTA_WAYS; w++) begin
          tag_ff[s][w] <= '0;
          phys_ff[s][w] <= '0;
        end
      end
    end else begin
      if (ent.wr) begin
        tag_ff[ent.idx][ent.wr_way] <= ent.wr_tag;
        phys_ff[ent.idx][ent.wr_way] <= ent.wr_phys;
      end
      if (ent.touch) begin
        lru_ff[ent.idx] <= lru_upd(ent.rd_lru, ent.touch_way);
      end
    end
  end
endmodule : tta_array
`default_nettype wire

/* File: src/tta_test_access.sv */
// Test access registers for the translation lookaside buffer.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Control bit 0 set starts a lookup, clear starts a buffer write.
// - A lookup searches with control bits 31:12; a hit updates both registers, a miss only data.
// - A buffer write allocates an entry to the page in control bits 31:12.
// - On a write, control bit 11 makes the entry valid or invalidates it.
// - Pairs 10:9, 8:7, 6:5 match never, on 0, on 1 or on either value.
// - On a write pair 01 clears and 10 sets the attribute; 00, 11 are unused.
// - Data bits 31:12 take the hit's physical page, or supply it on write.
// - A lookup reports the prior LRU state in data bits 9:7; writes ignore it.
// - A lookup sets data bit 4 on a hit and clears it on a miss.
// - A write with data bit 4 set uses set bits 3:2, else the LRU victim.
// - A lookup hit reports the matching set in data bits 3:2.
// - The buffer holds 32 entries, four-way, 24-bit tags and 20-bit data.
// - Only most-privileged register moves may reach the registers.
module tta_test_access (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic priv0_i,
  input wire logic ctrl_wr_i,
  input wire logic data_wr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] ctrl_o,
  output logic [31:0] data_o,
  output logic busy_o,
  output logic refused_o
);
  import tta_pkg::*;

  tta_entry_if ent ();
  tta_array u_array (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ent(ent)
  );

  tta_state_t state_ff, nxt_state;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] data_ff, nxt_data;
  logic busy_ff, refused_ff;

  // A pair code matches a stored bit: 01 on zero, 10 on one, 11 always.
  function automatic logic pair_match(input logic [1:0] p, input logic b);
    return b ? p[1] : p[0];
  endfunction : pair_match

  // Pseudo-LRU victim: least recent pair, then least recent way in it.
  function automatic logic [1:0] lru_victim(input logic [2:0] l);
    return l[0] ? {1'b1, l[2]} : {1'b0, l[1]};
  endfunction : lru_victim

  // A stored attribute reads back as the write code that sets it.
  function automatic logic [1:0] pair_code(input logic b);
    return b ? TTA_PAIR_SET : TTA_PAIR_CLR;
  endfunction : pair_code

  // Only the set code stores a one, so undefined codes store a zero.
  function automatic logic pair_write(input logic [1:0] p);
    return p == TTA_PAIR_SET;
  endfunction : pair_write

  // Page field of either register word.
  function automatic logic [TTA_PAGE_W-1:0] page_of(input logic [31:0] r);
    return r[TTA_PAGE_MSB:TTA_PAGE_LSB];
  endfunction : page_of

  // Register moves from a lower privilege level are refused outright.
  wire run = state_ff == TTA_RUN;
  wire any_strobe = ctrl_wr_i | data_wr_i;
  wire bad_strobe = any_strobe & ~priv0_i;
  wire ok_c = ctrl_wr_i & priv0_i;
  // A control move in the same cycle wins over a data move.
  wire ok_d = data_wr_i & priv0_i & ~ctrl_wr_i;
  wire [31:0] ctrl_wval = wdata_i & TTA_CTRL_MASK;
  wire [31:0] data_wval = wdata_i & TTA_DATA_MASK;

  wire is_lookup = ctrl_ff[TTA_CMD_BIT];
  wire do_lookup = run & is_lookup;
  wire do_write = run & ~is_lookup;

  wire [TTA_PAGE_W-1:0] lin = page_of(ctrl_ff);
  wire [TTA_IDX_W-1:0] set_idx = lin[TTA_IDX_W-1:0];
  wire [1:0] pd = ctrl_ff[TTA_DIRTY_LSB+:2];
  wire [1:0] pu = ctrl_ff[TTA_USER_LSB+:2];
  wire [1:0] pr = ctrl_ff[TTA_RW_LSB+:2];

  // Each way is judged on valid, page and the three attribute pairs.
  logic [TTA_WAYS-1:0] way_valid;
  logic [TTA_WAYS-1:0] way_page_eq;
  logic [TTA_WAYS-1:0] way_attr_ok;
  logic [TTA_WAYS-1:0] way_hit;
  always_comb begin
    for (int w = 0; w < TTA_WAYS; w++) begin
      way_valid[w] = ent.rd_tag[w].valid;
      way_page_eq[w] = ent.rd_tag[w].page == lin;
      way_attr_ok[w] = pair_match(pd, ent.rd_tag[w].dirty)
        && pair_match(pu, ent.rd_tag[w].user)
        && pair_match(pr, ent.rd_tag[w].rw);
      way_hit[w] = way_valid[w] && way_page_eq[w] && way_attr_ok[w];
    end
  end
  wire any_hit = |way_hit;
  logic [1:0] hit_way;
  always_comb begin
    hit_way = 2'h0;
    for (int w = TTA_WAYS - 1; w >= 0; w--) begin
      if (way_hit[w]) begin
        hit_way = w[1:0];
      end
    end
  end

  // A write either names its set or takes the least recent way.
  wire use_rep = data_ff[TTA_HIT_BIT];
  wire [1:0] rep_set = data_ff[TTA_SET_LSB+:2];
  wire [1:0] victim = lru_victim(ent.rd_lru);
  wire [1:0] wr_way = use_rep ? rep_set : victim;
  wire [TTA_PAGE_W-1:0] wr_phys = page_of(data_ff);

  // Software must avoid the undefined pair codes on a write.
  tta_tag_t new_tag;
  always_comb begin
    new_tag.valid = ctrl_ff[TTA_VALID_BIT];
    new_tag.dirty = pair_write(pd);
    new_tag.user = pair_write(pu);
    new_tag.rw = pair_write(pr);
    new_tag.page = lin;
  end

  assign ent.idx = set_idx;
  assign ent.wr = do_write;
  assign ent.wr_way = wr_way;
  assign ent.wr_tag = new_tag;
  assign ent.wr_phys = wr_phys;
  // A miss leaves the replacement order alone.
  assign ent.touch = do_write | (do_lookup & any_hit);
  assign ent.touch_way = is_lookup ? hit_way : wr_way;

  tta_tag_t ht;
  assign ht = ent.rd_tag[hit_way];
  wire [TTA_PAGE_W-1:0] hit_phys = ent.rd_phys[hit_way];
  wire [1:0] code_d = pair_code(ht.dirty);
  wire [1:0] code_u = pair_code(ht.user);
  wire [1:0] code_r = pair_code(ht.rw);

  // The LRU field reports the order before this lookup touched it.
  logic [31:0] lkp_data;
  always_comb begin
    lkp_data = data_ff;
    lkp_data[TTA_LRU_LSB+:3] = ent.rd_lru;
    lkp_data[TTA_HIT_BIT] = any_hit;
    if (any_hit) begin
      lkp_data[TTA_PAGE_MSB:TTA_PAGE_LSB] = hit_phys;
      lkp_data[TTA_SET_LSB+:2] = hit_way;
    end
  end

  // A miss leaves the page, the set and the control fields as written.
  logic [31:0] lkp_ctrl;
  always_comb begin
    lkp_ctrl = ctrl_ff;
    if (any_hit) begin
      lkp_ctrl[TTA_VALID_BIT] = ht.valid;
      lkp_ctrl[TTA_DIRTY_LSB+:2] = code_d;
      lkp_ctrl[TTA_USER_LSB+:2] = code_u;
      lkp_ctrl[TTA_RW_LSB+:2] = code_r;
    end
  end

  // An accepted control move runs for exactly one cycle; moves that
  // arrive meanwhile are dropped silently.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      TTA_IDLE: begin
        if (ok_c) begin
          nxt_state = TTA_RUN;
        end
      end
      TTA_RUN: begin
        nxt_state = TTA_IDLE;
      end
      default: begin
        nxt_state = TTA_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    unique case (state_ff)
      TTA_IDLE: begin
        if (ok_c) begin
          nxt_ctrl = ctrl_wval;
        end
      end
      TTA_RUN: begin
        if (is_lookup) begin
          nxt_ctrl = lkp_ctrl;
        end
      end
      default: begin
        nxt_ctrl = ctrl_ff;
      end
    endcase
  end

  always_comb begin
    nxt_data = data_ff;
    unique case (state_ff)
      TTA_IDLE: begin
        if (ok_d) begin
          nxt_data = data_wval;
        end
      end
      TTA_RUN: begin
        if (is_lookup) begin
          nxt_data = lkp_data;
        end
      end
      default: begin
        nxt_data = data_ff;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff <= TTA_IDLE;
      ctrl_ff <= TTA_CTRL_RST;
      data_ff <= TTA_DATA_RST;
      busy_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      data_ff <= nxt_data;
      busy_ff <= nxt_state == TTA_RUN;
      refused_ff <= bad_strobe;
    end
  end

  assign ctrl_o = ctrl_ff;
  assign data_o = data_ff;
  assign busy_o = busy_ff;
  assign refused_o = refused_ff;
endmodule : tta_test_access
`default_nettype wire

/* File: tb/tta_test_access_monitor.sv */
// Checker of the buffer test access port behaviour.
`timescale 1ns/10ps
`default_nettype none
module tta_test_access_monitor
  import tta_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic priv0_i,
  input wire logic ctrl_wr_i,
  input wire logic data_wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] ctrl_o,
  input wire logic [31:0] data_o,
  input wire logic busy_o,
  input wire logic refused_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire logic go = ctrl_wr_i && priv0_i && !busy_o;
  wire logic bad = (ctrl_wr_i || data_wr_i) && !priv0_i;
  wire logic lkp = busy_o && ctrl_o[0];
  property p_start;
    go |=> busy_o && ctrl_o == ($past(wdata_i) & TTA_CTRL_MASK);
  endproperty
  a_start: assert property (p_start) else $error("control write lost");
  property p_done;
    busy_o |=> !busy_o;
  endproperty
  a_done: assert property (p_done) else $error("busy too long");
  property p_data;
    data_wr_i && priv0_i && !ctrl_wr_i && !busy_o
      |=> data_o == ($past(wdata_i) & TTA_DATA_MASK);
  endproperty
  a_data: assert property (p_data) else $error("data write lost");
  property p_ref;
    bad |=> refused_o;
  endproperty
  a_ref: assert property (p_ref) else $error("no refusal");
  property p_keep;
    bad && !busy_o |=> $stable(ctrl_o) && $stable(data_o);
  endproperty
  a_keep: assert property (p_keep) else $error("refused write landed");
  property p_wrkeep;
    busy_o && !ctrl_o[0] |=> $stable(data_o) && $stable(ctrl_o);
  endproperty
  a_wrkeep: assert property (p_wrkeep) else $error("write moved regs");
  property p_page;
    busy_o |=> ctrl_o[31:12] == $past(ctrl_o[31:12])
      && ctrl_o[0] == $past(ctrl_o[0]);
  endproperty
  a_page: assert property (p_page) else $error("page changed");
  property p_miss;
    lkp ##1 !data_o[4] |-> data_o[31:12] == $past(data_o[31:12])
      && $stable(ctrl_o);
  endproperty
  a_miss: assert property (p_miss) else $error("miss changed regs");
  property p_hit;
    lkp ##1 data_o[4] |-> ctrl_o[11] && ^ctrl_o[10:9] && ^ctrl_o[8:7]
      && ^ctrl_o[6:5];
  endproperty
  a_hit: assert property (p_hit) else $error("bad hit codes");
  c_hit: cover property (lkp ##1 data_o[4]);
  c_miss: cover property (lkp ##1 !data_o[4]);
  c_ref: cover property (bad ##1 refused_o);
endmodule : tta_test_access_monitor
bind tta_test_access tta_test_access_monitor u_tta_test_access_monitor (
  .clk_i(clk_i), .srst_i(srst_i), .priv0_i(priv0_i), .ctrl_wr_i(ctrl_wr_i),
  .data_wr_i(data_wr_i), .wdata_i(wdata_i), .ctrl_o(ctrl_o),
  .data_o(data_o), .busy_o(busy_o), .refused_o(refused_o));
`default_nettype wire

/* File: tb/tta_test_access_bench.sv */
// Self-checking bench for the buffer test access registers.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tta_test_access_bench;
  import tta_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic priv0_i = 1'b1;
  logic ctrl_wr_i = 1'b0;
  logic data_wr_i = 1'b0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] ctrl_o;
  logic [31:0] data_o;
  logic busy_o;
  logic refused_o;
  int fails = 0;
  int comparisons = 0;
  logic [19:0] pg;
  logic [19:0] ph;
  logic [2:0] r;
  logic [5:0] at;
  logic [1:0] wy;
  always #5 clk_i = ~clk_i;
  tta_test_access u_tta_test_access (.clk_i(clk_i), .srst_i(srst_i),
    .priv0_i(priv0_i), .ctrl_wr_i(ctrl_wr_i), .data_wr_i(data_wr_i),
    .wdata_i(wdata_i), .ctrl_o(ctrl_o), .data_o(data_o), .busy_o(busy_o),
    .refused_o(refused_o));
  function automatic logic [31:0] ctl(input logic c, input logic v,
    input logic [5:0] a);
    return {pg, v, a, 4'h0, c};
  endfunction : ctl
  // Order bits after one touch of way k from the all-zero reset order.
  function automatic logic [2:0] lru_exp(input logic [1:0] k);
    logic [2:0] l;
    l = 3'h0;
    l[0] = !k[1];
    if (k[1]) l[2] = !k[0];
    else l[1] = !k[0];
    return l;
  endfunction : lru_exp
  // The extra edge after a control write lets the operation finish.
  task put(input logic c, input logic [31:0] v, input logic p);
    @(posedge clk_i);
    ctrl_wr_i <= c;
    data_wr_i <= !c;
    wdata_i <= v;
    priv0_i <= p;
    @(posedge clk_i);
    ctrl_wr_i <= 1'b0;
    data_wr_i <= 1'b0;
    priv0_i <= 1'b1;
    if (c && p) @(posedge clk_i);
    #1;
  endtask : put
  task op(input logic [31:0] c, input logic [31:0] d);
    put(1'b0, d, 1'b1);
    put(1'b1, c, 1'b1);
  endtask : op
  task final_report;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    fails++;
    final_report();
  end
  initial begin
    void'($urandom(32'ha1c2));
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    put(1'b0, 32'hffff_ffff, 1'b1);
    `CHK(data_o, TTA_DATA_MASK)
    $display("test reserved done");
    for (int i = 0; i < 8; i++) begin
      pg = $urandom();
      pg[2:0] = i[2:0];
      ph = $urandom();
      r = $urandom();
      at = {r[0], !r[0], r[1], !r[1], r[2], !r[2]};
      // A fresh set names way 0 as least recent.
      wy = i[0] ? i[1:0] : 2'h0;
      op(ctl(1'b0, 1'b1, at), {ph, 7'h0, i[0], i[1:0], 2'h0});
      op(ctl(1'b1, 1'b0, 6'h3f), {~ph, 12'h0});
      `CHK(data_o[4], 1'b1)
      `CHK(data_o[31:12], ph)
      `CHK(ctrl_o, ctl(1'b1, 1'b1, at))
      `CHK(data_o[3:2], wy)
      `CHK(data_o[9:7], lru_exp(wy))
      op(ctl(1'b1, 1'b0, at ^ 6'h30), 32'h0);
      `CHK(data_o[4], 1'b0)
      op(ctl(1'b1, 1'b0, at & 6'h33), 32'h0);
      `CHK(data_o[4], 1'b0)
      op(ctl(1'b1, 1'b0, at), 32'h0);
      `CHK(data_o[4], 1'b1)
      `CHK(data_o[3:2], wy)
      `CHK(data_o[9:7], lru_exp(wy))
      put(1'b1, ctl(1'b0, 1'b0, at), 1'b0);
      `CHK(refused_o, 1'b1)
      `CHK(busy_o, 1'b0)
      op(ctl(1'b0, 1'b0, at), {ph, 7'h0, 1'b1, wy, 2'h0});
      op(ctl(1'b1, 1'b0, 6'h3f), 32'h0);
      `CHK(data_o[4], 1'b0)
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule : tta_test_access_bench
`default_nettype wire
